// ==== core/ext_irq_slice.sv ====
// How it works
// - the secondary converter window request passes only while mask bit 3 is one.
// - mask bit 2 gates the fourth timer overflow request.
// - mask bit 1 gates the primary converter done request.
// - mask bit 0 gates the third timer overflow request.
// - the priority register answers at 0xf6 whatever the page select holds.
// - the priority register resets to zero, bits 6..0 read and write, bit 7 reserved.
// - priority bit 6 puts comparator c at the high level when set.
// - priority bit 5 puts comparator b at the high level when set.
// - priority bit 4 puts comparator a at the high level when set.
// - priority bit 3 puts the counter array at the high level when set.
// - priority bit 2 puts the primary window compare at the high level when set.
// - priority bit 1 puts the management bus at the high level when set.
// - priority bit 0 puts the serial peripheral at the high level when set.
// - the mask register answers at 0xe7 on every page, resets to zero, bit 3 window mask.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_slice (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_rd_hit,
    input wire logic sec_conv_window_flag,
    input wire logic fourth_timer_overflow_flag,
    input wire logic prim_conv_done_flag,
    input wire logic third_timer_overflow_flag,
    input wire logic [irq_slice_pkg::N_MASKED-1:0] masked_src_priority,
    input wire logic [irq_slice_pkg::N_PRIO-1:0] prio_src_flags,
    input wire logic [irq_slice_pkg::N_PRIO-1:0] prio_src_enables,
    output logic [3:0] ext_irq_mask_first,
    output logic [7:0] ext_irq_priority_second,
    output logic irq_req,
    output logic irq_high,
    output logic [irq_slice_pkg::SRC_W-1:0] irq_src,
    output logic [irq_slice_pkg::N_SRC-1:0] irq_pending
);
    import irq_slice_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic mask_hit;
    logic prio_hit;
    logic [7:0] mask_raw;
    logic [7:0] prio_raw;
    logic [7:0] sfr_rdata_reg;
    logic [7:0] sfr_rdata_next;
    logic sfr_rd_hit_reg;

    // page select is deliberately not part of either decode
    sfr_byte_reg #(
        .ADDR(MASK_FIRST_ADDR),
        .RW_MASK(MASK_FIRST_RW),
        .RESET_VAL(MASK_FIRST_RESET)
    ) u_mask_first (
        .ref_clk(ref_clk),
        .rst(rst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .hit(mask_hit),
        .value(mask_raw)
    );

    sfr_byte_reg #(
        .ADDR(PRIO_SECOND_ADDR),
        .RW_MASK(PRIO_SECOND_RW),
        .RESET_VAL(PRIO_SECOND_RESET)
    ) u_prio_second (
        .ref_clk(ref_clk),
        .rst(rst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .hit(prio_hit),
        .value(prio_raw)
    );

    assign ext_irq_mask_first = mask_raw[3:0];
    assign ext_irq_priority_second = prio_raw;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        sfr_rdata_next = SFR_IDLE_DATA;
        if (mask_hit) begin
            sfr_rdata_next = mask_raw;
        end else if (prio_hit) begin
            // top bit never stored, so reads back zero
            sfr_rdata_next = prio_raw;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sfr_rdata_reg <= SFR_IDLE_DATA;
            sfr_rd_hit_reg <= 1'b0;
        end else if (sfr_rd) begin
            sfr_rdata_reg <= sfr_rdata_next;
            sfr_rd_hit_reg <= mask_hit | prio_hit;
        end else begin
            sfr_rd_hit_reg <= 1'b0;
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign sfr_rd_hit = sfr_rd_hit_reg;

    // ----------------------------------------
    // masking
    // ----------------------------------------
    logic [N_SRC-1:0] req_vec;
    logic [N_SRC-1:0] level_vec;

    always_comb begin
        req_vec = '0;
        req_vec[SRC_THIRD_TIMER] = third_timer_overflow_flag
            & mask_raw[THIRD_TIMER_BIT];
        req_vec[SRC_PRIM_CONV_DONE] = prim_conv_done_flag
            & mask_raw[PRIM_CONV_DONE_BIT];
        req_vec[SRC_FOURTH_TIMER] = fourth_timer_overflow_flag
            & mask_raw[FOURTH_TIMER_BIT];
        req_vec[SRC_SEC_CONV_WINDOW] = sec_conv_window_flag
            & mask_raw[SEC_CONV_WINDOW_BIT];
        // the other seven are masked by enables held elsewhere
        req_vec[N_SRC-1:N_MASKED] = prio_src_flags & prio_src_enables;
    end

    // ----------------------------------------
    // level selection
    // ----------------------------------------
    always_comb begin
        level_vec = '0;
        level_vec[N_MASKED-1:0] = masked_src_priority;
        level_vec[N_MASKED + SERIAL_PERIPH_BIT] =
            prio_raw[SERIAL_PERIPH_BIT];
        level_vec[N_MASKED + MGMT_BUS_BIT] =
            prio_raw[MGMT_BUS_BIT];
        level_vec[N_MASKED + PRIM_CONV_WINDOW_BIT] =
            prio_raw[PRIM_CONV_WINDOW_BIT];
        level_vec[N_MASKED + COUNTER_ARRAY_BIT] =
            prio_raw[COUNTER_ARRAY_BIT];
        level_vec[N_MASKED + COMPARATOR_A_BIT] =
            prio_raw[COMPARATOR_A_BIT];
        level_vec[N_MASKED + COMPARATOR_B_BIT] =
            prio_raw[COMPARATOR_B_BIT];
        level_vec[N_MASKED + COMPARATOR_C_BIT] =
            prio_raw[COMPARATOR_C_BIT];
    end

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    logic hi_any;
    logic lo_any;
    logic [SRC_W-1:0] hi_idx;
    logic [SRC_W-1:0] lo_idx;
    logic irq_req_reg;
    logic irq_high_reg;
    logic [SRC_W-1:0] irq_src_reg;
    logic [N_SRC-1:0] irq_pending_reg;

    irq_level_pick #(.N(N_SRC), .IDX_W(SRC_W)) u_pick_high (
        .req(req_vec & level_vec),
        .any(hi_any),
        .idx(hi_idx)
    );

    irq_level_pick #(.N(N_SRC), .IDX_W(SRC_W)) u_pick_low (
        .req(req_vec & ~level_vec),
        .any(lo_any),
        .idx(lo_idx)
    );

    // one register stage: the core sees a stable choice for a full cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_req_reg <= 1'b0;
            irq_high_reg <= 1'b0;
            irq_src_reg <= '0;
        end else if (hi_any) begin
            irq_req_reg <= 1'b1;
            irq_high_reg <= 1'b1;
            irq_src_reg <= hi_idx;
        end else if (lo_any) begin
            irq_req_reg <= 1'b1;
            irq_high_reg <= 1'b0;
            irq_src_reg <= lo_idx;
        end else begin
            irq_req_reg <= 1'b0;
            irq_high_reg <= 1'b0;
            irq_src_reg <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_pending_reg <= '0;
        end else begin
            irq_pending_reg <= req_vec;
        end
    end

    assign irq_req = irq_req_reg;
    assign irq_high = irq_high_reg;
    assign irq_src = irq_src_reg;
    assign irq_pending = irq_pending_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_prio_write;
        sfr_wr && sfr_addr == PRIO_SECOND_ADDR;
    endsequence

    sequence s_prio_read;
        sfr_rd && !sfr_wr && sfr_addr == PRIO_SECOND_ADDR;
    endsequence

    sequence s_mask_write;
        sfr_wr && sfr_addr == MASK_FIRST_ADDR;
    endsequence

    AST_SEC_WINDOW_BLOCK: assert property (
        !mask_raw[SEC_CONV_WINDOW_BIT]
        |=> !(irq_req && irq_src == SRC_SEC_CONV_WINDOW))
        else $error("blocked window request reached the core");

    AST_SEC_WINDOW_PASS: assert property (
        sec_conv_window_flag && mask_raw[SEC_CONV_WINDOW_BIT]
        && req_vec == (N_SRC'(1) << SRC_SEC_CONV_WINDOW)
        |=> irq_req && irq_src == SRC_SEC_CONV_WINDOW)
        else $error("enabled window request not passed");

    AST_FOURTH_TIMER_GATE: assert property (
        irq_req && irq_src == SRC_FOURTH_TIMER
        |-> $past(fourth_timer_overflow_flag)
            && $past(mask_raw[FOURTH_TIMER_BIT]))
        else $error("fourth timer request without flag and mask");

    AST_PRIM_DONE_GATE: assert property (
        irq_req && irq_src == SRC_PRIM_CONV_DONE
        |-> $past(prim_conv_done_flag)
            && $past(mask_raw[PRIM_CONV_DONE_BIT]))
        else $error("conversion done request without flag and mask");

    AST_THIRD_TIMER_GATE: assert property (
        third_timer_overflow_flag && !mask_raw[THIRD_TIMER_BIT]
        |=> !irq_pending[SRC_THIRD_TIMER])
        else $error("masked third timer request pending");

    AST_PRIO_PAGE_FREE: assert property (
        s_prio_write ##1 s_prio_read
        |=> sfr_rdata == ($past(sfr_wdata, 2) & PRIO_SECOND_RW)
            && sfr_rd_hit)
        else $error("priority register write not read back");

    // page select must never gate the decode
    AST_PRIO_ANY_PAGE: assert property (
        (s_prio_read and sfr_page != 8'h00) |=> sfr_rd_hit)
        else $error("priority register missed on a paged read");

    AST_MASK_READBACK: assert property (
        s_mask_write ##1 (sfr_rd && !sfr_wr
            && sfr_addr == MASK_FIRST_ADDR)
        |=> sfr_rdata == ($past(sfr_wdata, 2) & MASK_FIRST_RW))
        else $error("mask register write not read back");

    AST_RESET_ZERO: assert property (
        $past(rst) |-> ext_irq_priority_second == PRIO_SECOND_RESET
            && ext_irq_mask_first == MASK_FIRST_RESET[3:0])
        else $error("registers not zero after reset");

    AST_COMP_C_LEVEL: assert property (
        req_vec == (N_SRC'(1) << SRC_COMPARATOR_C)
        |=> irq_req && irq_high == $past(prio_raw[COMPARATOR_C_BIT]))
        else $error("comparator c level wrong");

    AST_LEVEL_MAP: assert property (
        irq_req |-> ((($past(level_vec) >> irq_src) & N_SRC'(1))
            == N_SRC'(irq_high)))
        else $error("granted source at wrong level");

    AST_SERIAL_LEVEL: assert property (
        req_vec == (N_SRC'(1) << SRC_SERIAL_PERIPH)
        && prio_raw[SERIAL_PERIPH_BIT]
        |=> irq_req && irq_high && irq_src == SRC_SERIAL_PERIPH)
        else $error("serial peripheral not high");

    AST_HIGH_FIRST: assert property (
        hi_any && lo_any |=> irq_req && irq_high)
        else $error("low request beat a high one");

    AST_NO_UNMASKED: assert property (
        req_vec == '0 |=> !irq_req)
        else $error("request with nothing enabled");

    AST_RSVD_BIT: assert property (
        (s_prio_write and sfr_wdata[PRIO_RSVD_BIT])
        |=> !ext_irq_priority_second[PRIO_RSVD_BIT])
        else $error("reserved priority bit stored");
endmodule
`default_nettype wire

// ==== core/irq_level_pick.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_level_pick #(
    parameter int N = 11,
    parameter int IDX_W = 4
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [IDX_W-1:0] idx
);
    // scan downward so the lowest pending index is kept
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/sfr_byte_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfr_byte_reg #(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] RW_MASK = 8'hff,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic hit,
    output logic [7:0] value
);
    logic [7:0] value_reg;

    // decoded on every page; the page select never reaches here
    assign hit = (sfr_addr == ADDR);
    assign value = value_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            value_reg <= RESET_VAL;
        end else if (sfr_wr && hit) begin
            // bits outside the mask never store
            value_reg <= sfr_wdata & RW_MASK;
        end
    end
endmodule
`default_nettype wire

// ==== include/irq_slice_pkg.sv ====
`default_nettype none
package irq_slice_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] MASK_FIRST_ADDR = 8'he7;
    localparam logic [7:0] PRIO_SECOND_ADDR = 8'hf6;
    localparam logic [7:0] MASK_FIRST_RESET = 8'h00;
    localparam logic [7:0] PRIO_SECOND_RESET = 8'h00;
    // writable bits; the rest store nothing and read as zero
    localparam logic [7:0] MASK_FIRST_RW = 8'h0f;
    localparam logic [7:0] PRIO_SECOND_RW = 8'h7f;
    localparam logic [7:0] SFR_IDLE_DATA = 8'h00;
    // ----------------------------------------
    // mask register fields
    // ----------------------------------------
    localparam int THIRD_TIMER_BIT = 0;
    localparam int PRIM_CONV_DONE_BIT = 1;
    localparam int FOURTH_TIMER_BIT = 2;
    localparam int SEC_CONV_WINDOW_BIT = 3;
    // ----------------------------------------
    // priority register fields
    // ----------------------------------------
    localparam int SERIAL_PERIPH_BIT = 0;
    localparam int MGMT_BUS_BIT = 1;
    localparam int PRIM_CONV_WINDOW_BIT = 2;
    localparam int COUNTER_ARRAY_BIT = 3;
    localparam int COMPARATOR_A_BIT = 4;
    localparam int COMPARATOR_B_BIT = 5;
    localparam int COMPARATOR_C_BIT = 6;
    localparam int PRIO_RSVD_BIT = 7;
    // ----------------------------------------
    // source numbering, lowest wins within a level
    // ----------------------------------------
    localparam int N_SRC = 11;
    localparam int N_MASKED = 4;
    localparam int N_PRIO = 7;
    localparam int SRC_W = 4;
    localparam logic [3:0] SRC_THIRD_TIMER = 4'h0;
    localparam logic [3:0] SRC_PRIM_CONV_DONE = 4'h1;
    localparam logic [3:0] SRC_FOURTH_TIMER = 4'h2;
    localparam logic [3:0] SRC_SEC_CONV_WINDOW = 4'h3;
    localparam logic [3:0] SRC_SERIAL_PERIPH = 4'h4;
    localparam logic [3:0] SRC_COMPARATOR_C = 4'ha;
endpackage
`default_nettype wire

// ==== verif/irq_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_partner (
    input wire logic ref_clk,
    input wire logic [irq_slice_pkg::N_SRC-1:0] src_pattern,
    output logic sec_conv_window_flag,
    output logic fourth_timer_overflow_flag,
    output logic prim_conv_done_flag,
    output logic third_timer_overflow_flag,
    output logic [irq_slice_pkg::N_PRIO-1:0] prio_src_flags
);
    // ----------------------------------------
    // peripheral flags
    // ----------------------------------------
    // flags move only on the clock edge, like real peripheral flops
    initial begin
        third_timer_overflow_flag = 1'b0;
        prim_conv_done_flag = 1'b0;
        fourth_timer_overflow_flag = 1'b0;
        sec_conv_window_flag = 1'b0;
        prio_src_flags = '0;
    end
    always @(posedge ref_clk) begin
        third_timer_overflow_flag <= src_pattern[0];
        prim_conv_done_flag <= src_pattern[1];
        fourth_timer_overflow_flag <= src_pattern[2];
        sec_conv_window_flag <= src_pattern[3];
        prio_src_flags <= src_pattern[10:4];
    end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import irq_slice_pkg::*;
    typedef struct {
        logic [7:0] mask;
        logic [7:0] prio;
        logic [3:0] msp;
        logic [10:0] pat;
        logic [6:0] en;
        logic [5:0] exp;
    } row_s;
    logic ref_clk, rst, sfr_wr, sfr_rd, sfr_rd_hit, irq_req, irq_high;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, prio_q;
    logic sec_w, t4, done0, t3;
    logic [3:0] masked_src_priority, mask_q, irq_src;
    logic [6:0] prio_src_flags, prio_src_enables;
    logic [10:0] irq_pending, src_pattern;
    int err_total = 0;
    int check_count = 0;
    // exp = {irq_req, irq_high, irq_src}
    row_s rows[18] = '{
        '{8'h08, 8'h00, 4'h0, 11'h008, 7'h00, 6'h23},
        '{8'h07, 8'h00, 4'h0, 11'h008, 7'h00, 6'h00},
        '{8'h04, 8'h00, 4'h0, 11'h004, 7'h00, 6'h22},
        '{8'h02, 8'h00, 4'h0, 11'h002, 7'h00, 6'h21},
        '{8'h01, 8'h00, 4'h0, 11'h001, 7'h00, 6'h20},
        '{8'h0e, 8'h00, 4'h0, 11'h00f, 7'h00, 6'h21},
        '{8'h0f, 8'h40, 4'h0, 11'h401, 7'h7f, 6'h3a},
        '{8'h0f, 8'h20, 4'h0, 11'h201, 7'h7f, 6'h39},
        '{8'h0f, 8'h10, 4'h0, 11'h101, 7'h7f, 6'h38},
        '{8'h0f, 8'h08, 4'h0, 11'h081, 7'h7f, 6'h37},
        '{8'h0f, 8'h04, 4'h0, 11'h041, 7'h7f, 6'h36},
        '{8'h0f, 8'h02, 4'h0, 11'h021, 7'h7f, 6'h35},
        '{8'h0f, 8'h01, 4'h0, 11'h011, 7'h7f, 6'h34},
        '{8'h0f, 8'h7f, 4'h0, 11'h401, 7'h00, 6'h20},
        '{8'h0f, 8'h00, 4'h1, 11'h011, 7'h7f, 6'h30},
        '{8'h0f, 8'h00, 4'h0, 11'h000, 7'h7f, 6'h00},
        '{8'h00, 8'h40, 4'h0, 11'h400, 7'h40, 6'h3a},
        '{8'h00, 8'h01, 4'h0, 11'h010, 7'h01, 6'h34}
    };
    // ----------------------------------------
    // clock and instances
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ext_irq_slice ext_irq_slice_i (
        .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
        .sec_conv_window_flag(sec_w), .fourth_timer_overflow_flag(t4),
        .prim_conv_done_flag(done0), .third_timer_overflow_flag(t3),
        .masked_src_priority(masked_src_priority),
        .prio_src_flags(prio_src_flags),
        .prio_src_enables(prio_src_enables),
        .ext_irq_mask_first(mask_q), .ext_irq_priority_second(prio_q),
        .irq_req(irq_req), .irq_high(irq_high), .irq_src(irq_src),
        .irq_pending(irq_pending)
    );
    irq_partner irq_partner_i (
        .ref_clk(ref_clk), .src_pattern(src_pattern),
        .sec_conv_window_flag(sec_w), .fourth_timer_overflow_flag(t4),
        .prim_conv_done_flag(done0), .third_timer_overflow_flag(t3),
        .prio_src_flags(prio_src_flags)
    );
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one idle cycle between strobes keeps each pulse a single cycle
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d,
                             input logic [7:0] pg);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_page = pg;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp,
                            input logic hit);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk_reg(sfr_rdata, exp);
        chk_reg({7'h00, sfr_rd_hit}, {7'h00, hit});
    endtask
    // write then read on the very next edge, no idle cycle between
    task automatic sfr_write_read(input logic [7:0] a, input logic [7:0] d,
                                  input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk_reg(sfr_rdata, exp);
        chk_reg({7'h00, sfr_rd_hit}, 8'h01);
    endtask
    task automatic set_src(input logic [10:0] p, input logic [6:0] e,
                           input logic [3:0] m);
        @(negedge ref_clk);
        src_pattern = p;
        prio_src_enables = e;
        masked_src_priority = m;
        // one edge for the flags to land, one for the registered answer
        repeat (2) @(negedge ref_clk);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_page = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        src_pattern = '0;
        prio_src_enables = '0;
        masked_src_priority = '0;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        chk_reg(prio_q, PRIO_SECOND_RESET);
        chk_reg({4'h0, mask_q}, MASK_FIRST_RESET);
        sfr_read(PRIO_SECOND_ADDR, 8'h00, 1'b1);
        sfr_read(MASK_FIRST_ADDR, 8'h00, 1'b1);
        sfr_write(PRIO_SECOND_ADDR, 8'hff, 8'h3c);
        chk_reg(prio_q, 8'h7f);
        sfr_read(PRIO_SECOND_ADDR, 8'h7f, 1'b1);
        sfr_write(MASK_FIRST_ADDR, 8'hff, 8'hc3);
        sfr_read(MASK_FIRST_ADDR, 8'h0f, 1'b1);
        sfr_write(8'hf7, 8'h00, 8'h00);
        sfr_read(8'h55, 8'h00, 1'b0);
        sfr_read(PRIO_SECOND_ADDR, 8'h7f, 1'b1);
        sfr_write(PRIO_SECOND_ADDR, 8'h80, 8'h0f);
        sfr_read(PRIO_SECOND_ADDR, 8'h00, 1'b1);
        sfr_write_read(PRIO_SECOND_ADDR, 8'hd5, 8'h55);
        sfr_write_read(MASK_FIRST_ADDR, 8'ha6, 8'h06);
        foreach (rows[i]) begin
            sfr_write(MASK_FIRST_ADDR, rows[i].mask, 8'(i));
            sfr_write(PRIO_SECOND_ADDR, rows[i].prio, 8'(i));
            set_src(rows[i].pat, rows[i].en, rows[i].msp);
            chk_irq({5'h00, irq_req, irq_high, irq_src},
                    {5'h00, rows[i].exp});
        end
        // masked vector keeps only enabled sources
        sfr_write(MASK_FIRST_ADDR, 8'h05, 8'h00);
        set_src(11'h7ff, 7'h55, 4'h0);
        chk_irq(irq_pending, 11'h555);
        // reset in mid-run clears both registers and the request
        sfr_write(PRIO_SECOND_ADDR, 8'h7f, 8'h00);
        @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        chk_reg(prio_q, 8'h00);
        chk_reg({4'h0, mask_q}, 8'h00);
        chk_irq({10'h000, irq_req}, 11'h000);
        rst = 1'b0;
        sfr_read(PRIO_SECOND_ADDR, 8'h00, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
